// File: rtl/dhc_debug_csrs.sv
// Debug control/status and trigger compare value registers of the hart
//
// How it works
// RL1: 32-bit compare value register, resets zero
// RL2: Compare value is address or store data
// RL3: Select 0 matches address, 1 data
// RL4: Masked mode compares top 31-minus-lowest-zero bits
// RL5: Control access outside debug mode traps illegal
// RL6: Version field bits 31:28 read four
// RL7: Bit 15 sends breakpoint into debug mode
// RL8: Bit 11 enables interrupts while stepping
// RL9: Debugger changes step bits only when halted
// RL10: Bit 10 freezes counters while halted
// RL11: Bit 9 reads zero, timers keep running
// RL12: Bits 8:6 hold debug entry cause code
// RL13: Simultaneous causes record the highest priority
// RL14: Bit 4 zero, privilege override ignored
// RL15: Bit 3 shows pending non-maskable interrupt
// RL16: Step bit runs one instruction then halts
// RL17: Stepped exception enters debug before handler
// RL18: Bits 1:0 capture entry privilege, reset three
// RL19: Cause and privilege change only on entry
`timescale 1ns/1ps
`default_nettype none
module dhc_debug_csrs (
   input  wire logic        CORE_CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        CLK_EN_I,
   input  wire logic        CSR_VALID_I,
   input  wire logic        CSR_WRITE_I,
   input  wire logic [11:0] CSR_ADDR_I,
   input  wire logic [31:0] CSR_WDATA_I,
   input  wire logic        TRIG_SELECT_I,
   input  wire logic        TRIG_MASKED_I,
   input  wire logic [31:0] TRIG_ADDRESS_I,
   input  wire logic [31:0] TRIG_DATA_I,
   input  wire logic        ENTER_TRIGGER_I,
   input  wire logic        ENTER_EBREAK_I,
   input  wire logic        ENTER_RSTHALT_I,
   input  wire logic        ENTER_HALTREQ_I,
   input  wire logic        RESUME_I,
   input  wire logic        INSN_RETIRE_I,
   input  wire logic        INSN_EXCEPTION_I,
   input  wire logic [1:0]  CUR_PRIV_I,
   input  wire logic        NMI_PENDING_I,
   output logic [31:0]      CSR_RDATA_O,
   output logic             CSR_ILLEGAL_O,
   output logic             CSR_DONE_O,
   output logic             TRIG_HIT_O,
   output logic             DEBUG_MODE_O,
   output logic             EBREAK_TO_DEBUG_O,
   output logic             STEP_IRQ_EN_O,
   output logic             COUNT_STOP_O,
   output logic             MPRV_IGNORE_O
);
   logic [31:0]         compare_value;
   logic                ebreakm;
   logic                stepie;
   logic                stopcount;
   logic                step;
   logic [2:0]          cause;
   logic [1:0]          prv;
   logic                nmi_s1;
   logic                nmi_s2;
   logic                nmi_s3;
   logic                nmi_pending;
   dhc_pkg::dhc_state_t state;
   dhc_pkg::dhc_state_t next_state;
   dhc_pkg::dhc_cause_t picked_cause;
   logic                any_entry;
   logic                step_done;
   logic                hit;
   logic                in_debug;
   logic                wr_tcv;
   logic                wr_dcs;
   logic                dcs_denied;
   logic [31:0]         dcs_view;

   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
      addr_is = (a == ref_a);
   endfunction : addr_is

   function automatic logic is_halted(input dhc_pkg::dhc_state_t s);
      is_halted = (s == dhc_pkg::ST_HALTED);
   endfunction : is_halted

   assign in_debug   = is_halted(state);
   // RL5 control register reachable only in debug mode
   assign dcs_denied = addr_is(CSR_ADDR_I, dhc_pkg::DCS_ADDR) && !in_debug;
   assign wr_tcv     = CSR_VALID_I && CSR_WRITE_I && addr_is(CSR_ADDR_I, dhc_pkg::TCV_ADDR);
   assign wr_dcs     = CSR_VALID_I && CSR_WRITE_I && addr_is(CSR_ADDR_I, dhc_pkg::DCS_ADDR)
                       && !dcs_denied;
   // RL17 stepped instruction that traps also ends the step
   assign step_done  = (state == dhc_pkg::ST_STEPPING) && (INSN_RETIRE_I || INSN_EXCEPTION_I);

   dhc_cause_pick u_pick (
      .trigger_i (ENTER_TRIGGER_I && !in_debug),
      .ebreak_i  (ENTER_EBREAK_I && ebreakm && !in_debug),
      .rsthalt_i (ENTER_RSTHALT_I && !in_debug),
      .haltreq_i (ENTER_HALTREQ_I && !in_debug),
      .step_i    (step_done),
      .cause_o   (picked_cause),
      .any_o     (any_entry)
   );

   dhc_trig_match u_match (
      .compare_i (compare_value),
      .address_i (TRIG_ADDRESS_I),
      .data_i    (TRIG_DATA_I),
      .select_i  (TRIG_SELECT_I),
      .masked_i  (TRIG_MASKED_I),
      .hit_o     (hit)
   );

   // NMI arrives from another part of the chip, so it is filtered on agreement
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         nmi_s1 <= 1'b0;
         nmi_s2 <= 1'b0;
         nmi_s3 <= 1'b0;
      end else if (CLK_EN_I) begin
         nmi_s1 <= NMI_PENDING_I;
         nmi_s2 <= nmi_s1;
         nmi_s3 <= nmi_s2;
      end
   end

   // A level counts only once two samples agree, so a glitch never shows
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         nmi_pending <= 1'b0;
      end else if (CLK_EN_I) begin
         if (nmi_s2 == nmi_s3) begin
            nmi_pending <= nmi_s3;
         end
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         dhc_pkg::ST_RUN: begin
            if (any_entry) begin
               next_state = dhc_pkg::ST_HALTED;
            end
         end
         dhc_pkg::ST_STEPPING: begin
            if (any_entry) begin
               next_state = dhc_pkg::ST_HALTED;
            end
         end
         dhc_pkg::ST_HALTED: begin
            // RL16 resume with step set runs one instruction
            if (RESUME_I) begin
               next_state = step ? dhc_pkg::ST_STEPPING : dhc_pkg::ST_RUN;
            end
         end
         default: next_state = dhc_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         state <= dhc_pkg::ST_RUN;
      end else if (CLK_EN_I) begin
         state <= next_state;
      end
   end

   // RL1 compare value register
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         compare_value <= dhc_pkg::TCV_RESET;
      end else if (CLK_EN_I && wr_tcv) begin
         compare_value <= CSR_WDATA_I;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         ebreakm   <= 1'b0;
         stepie    <= 1'b0;
         stopcount <= 1'b0;
         step      <= 1'b0;
      end else if (CLK_EN_I && wr_dcs) begin
         // RL7 breakpoint behaviour select
         ebreakm   <= CSR_WDATA_I[dhc_pkg::EBREAKM_BIT];
         // RL8 step interrupt enable
         stepie    <= CSR_WDATA_I[dhc_pkg::STEPIE_BIT];
         // RL10 counter freeze control
         stopcount <= CSR_WDATA_I[dhc_pkg::STOPCOUNT_BIT];
         // RL9 writes only land while halted, so the step bits stay stable
         step      <= CSR_WDATA_I[dhc_pkg::STEP_BIT];
      end
   end

   // RL19 cause and privilege held between entries
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         cause <= dhc_pkg::CAUSE_RESET;
         prv   <= dhc_pkg::PRV_RESET;
      end else if (CLK_EN_I && any_entry && !in_debug) begin
         // RL12 record entry reason
         cause <= picked_cause;
         // RL18 capture entry privilege
         prv   <= CUR_PRIV_I;
      end
   end

   always_comb begin
      dcs_view = 32'h0000_0000;
      // RL6 fixed version field
      dcs_view[dhc_pkg::VER_MSB:dhc_pkg::VER_LSB] = dhc_pkg::DEBUG_VER;
      dcs_view[dhc_pkg::EBREAKM_BIT]   = ebreakm;
      dcs_view[dhc_pkg::STEPIE_BIT]    = stepie;
      dcs_view[dhc_pkg::STOPCOUNT_BIT] = stopcount;
      // RL11 timers never stop, bit reads zero
      dcs_view[dhc_pkg::STOPTIME_BIT]  = 1'b0;
      dcs_view[dhc_pkg::CAUSE_MSB:dhc_pkg::CAUSE_LSB] = cause;
      // RL14 override enable reads zero
      dcs_view[dhc_pkg::MPRVEN_BIT]    = 1'b0;
      // RL15 pending NMI status
      dcs_view[dhc_pkg::NMIP_BIT]      = nmi_pending;
      dcs_view[dhc_pkg::STEP_BIT]      = step;
      dcs_view[dhc_pkg::PRV_MSB:dhc_pkg::PRV_LSB] = prv;
   end

   // Completion and trap flags: one cycle pulse after the access
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         CSR_DONE_O    <= 1'b0;
         CSR_ILLEGAL_O <= 1'b0;
      end else if (CLK_EN_I) begin
         CSR_DONE_O    <= CSR_VALID_I && !dcs_denied;
         // RL5 denied access raises illegal instruction
         CSR_ILLEGAL_O <= CSR_VALID_I && dcs_denied;
      end
   end

   // Registered read port: zero unless answered, so a denied read leaks nothing
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         CSR_RDATA_O <= 32'h0000_0000;
      end else if (CLK_EN_I) begin
         if (CSR_VALID_I && addr_is(CSR_ADDR_I, dhc_pkg::TCV_ADDR)) begin
            CSR_RDATA_O <= compare_value;
         end else if (CSR_VALID_I && addr_is(CSR_ADDR_I, dhc_pkg::DCS_ADDR) && !dcs_denied) begin
            CSR_RDATA_O <= dcs_view;
         end else begin
            CSR_RDATA_O <= 32'h0000_0000;
         end
      end
   end

   // Hit is registered so the core sees a clean level, one cycle late
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         TRIG_HIT_O <= 1'b0;
      end else if (CLK_EN_I) begin
         TRIG_HIT_O <= hit;
      end
   end

   // Halt level follows the state register exactly
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         DEBUG_MODE_O <= 1'b0;
      end else if (CLK_EN_I) begin
         DEBUG_MODE_O <= is_halted(next_state);
      end
   end

   // RL7 breakpoint routing seen by core
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         EBREAK_TO_DEBUG_O <= 1'b0;
      end else if (CLK_EN_I) begin
         EBREAK_TO_DEBUG_O <= ebreakm;
      end
   end

   // RL8 interrupts masked during step unless enabled
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         STEP_IRQ_EN_O <= 1'b0;
      end else if (CLK_EN_I) begin
         STEP_IRQ_EN_O <= (next_state != dhc_pkg::ST_STEPPING) || stepie;
      end
   end

   // RL10 freeze while halted or on entering breakpoint
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         COUNT_STOP_O <= 1'b0;
      end else if (CLK_EN_I) begin
         COUNT_STOP_O <= stopcount && (is_halted(next_state)
                         || (ENTER_EBREAK_I && ebreakm));
      end
   end

   // RL14 privilege override ignored in debug mode
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         MPRV_IGNORE_O <= 1'b0;
      end else if (CLK_EN_I) begin
         MPRV_IGNORE_O <= is_halted(next_state);
      end
   end
endmodule : dhc_debug_csrs
`default_nettype wire

// File: rtl/dhc_pkg.sv
// Constants and types for the debug halt control registers
package dhc_pkg;
   localparam logic [11:0] TCV_ADDR       = 12'h7a2;
   localparam logic [11:0] DCS_ADDR       = 12'h7b0;
   localparam logic [31:0] TCV_RESET      = 32'h0000_0000;
   localparam logic [3:0]  DEBUG_VER      = 4'h4;
   localparam int          VER_MSB        = 31;
   localparam int          VER_LSB        = 28;
   localparam int          EBREAKM_BIT    = 15;
   localparam int          STEPIE_BIT     = 11;
   localparam int          STOPCOUNT_BIT  = 10;
   localparam int          STOPTIME_BIT   = 9;
   localparam int          CAUSE_MSB      = 8;
   localparam int          CAUSE_LSB      = 6;
   localparam int          MPRVEN_BIT     = 4;
   localparam int          NMIP_BIT       = 3;
   localparam int          STEP_BIT       = 2;
   localparam int          PRV_MSB        = 1;
   localparam int          PRV_LSB        = 0;
   localparam logic [2:0]  CAUSE_RESET    = 3'h0;
   localparam logic [1:0]  PRV_RESET      = 2'h3;
   localparam logic [1:0]  PRV_MACHINE    = 2'h3;

   typedef enum logic [2:0] {
      CAUSE_NONE    = 3'h0,
      CAUSE_EBREAK  = 3'h1,
      CAUSE_TRIGGER = 3'h2,
      CAUSE_HALTREQ = 3'h3,
      CAUSE_STEP    = 3'h4,
      CAUSE_RSTHALT = 3'h5
   } dhc_cause_t;

   typedef enum logic [1:0] {
      ST_RUN      = 2'h0,
      ST_STEPPING = 2'h1,
      ST_HALTED   = 2'h2
   } dhc_state_t;
endpackage : dhc_pkg

// File: rtl/dhc_cause_pick.sv
// Priority pick of the debug entry cause
`timescale 1ns/1ps
`default_nettype none
module dhc_cause_pick (
   input  wire logic                 trigger_i,
   input  wire logic                 ebreak_i,
   input  wire logic                 rsthalt_i,
   input  wire logic                 haltreq_i,
   input  wire logic                 step_i,
   output var  dhc_pkg::dhc_cause_t  cause_o,
   output var  logic                 any_o
);
   always_comb begin
      // RL13 highest priority wins
      if (trigger_i) begin
         cause_o = dhc_pkg::CAUSE_TRIGGER;
      end else if (ebreak_i) begin
         cause_o = dhc_pkg::CAUSE_EBREAK;
      end else if (rsthalt_i) begin
         cause_o = dhc_pkg::CAUSE_RSTHALT;
      end else if (haltreq_i) begin
         cause_o = dhc_pkg::CAUSE_HALTREQ;
      end else if (step_i) begin
         cause_o = dhc_pkg::CAUSE_STEP;
      end else begin
         cause_o = dhc_pkg::CAUSE_NONE;
      end
      any_o = trigger_i | ebreak_i | rsthalt_i | haltreq_i | step_i;
   end
endmodule : dhc_cause_pick
`default_nettype wire

// File: rtl/dhc_trig_match.sv
// Compare of a trigger operand against the compare value, exact or masked
`timescale 1ns/1ps
`default_nettype none
module dhc_trig_match (
   input  wire logic [31:0] compare_i,
   input  wire logic [31:0] address_i,
   input  wire logic [31:0] data_i,
   input  wire logic        select_i,
   input  wire logic        masked_i,
   output var  logic        hit_o
);
   logic [31:0] operand;
   logic [31:0] care;
   logic        seen_zero;

   always_comb begin
      // RL3 address when select is 0, data when 1
      operand = select_i ? data_i : address_i;
      // RL4 ignore bits up to and including the lowest zero
      care      = 32'hffff_ffff;
      seen_zero = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (masked_i && !seen_zero) begin
            care[i] = 1'b0;
         end
         if (!compare_i[i]) begin
            seen_zero = 1'b1;
         end
      end
      // RL2 value is an address or store data
      hit_o = ((operand ^ compare_i) & care) == 32'h0000_0000;
   end
endmodule : dhc_trig_match
`default_nettype wire

// File: dv/dhc_debug_csrs_assertions.sv
// Port-level checks on the debug halt control registers
`timescale 1ns/1ps
`default_nettype none
module dhc_debug_csrs_chk (
   input wire logic        CORE_CLK_I,
   input wire logic        SYS_RST_I,
   input wire logic        CLK_EN_I,
   input wire logic        CSR_VALID_I,
   input wire logic        CSR_WRITE_I,
   input wire logic [11:0] CSR_ADDR_I,
   input wire logic        ENTER_TRIGGER_I,
   input wire logic        ENTER_EBREAK_I,
   input wire logic        ENTER_RSTHALT_I,
   input wire logic        ENTER_HALTREQ_I,
   input wire logic        RESUME_I,
   input wire logic        INSN_RETIRE_I,
   input wire logic        INSN_EXCEPTION_I,
   input wire logic [31:0] CSR_RDATA_O,
   input wire logic        CSR_ILLEGAL_O,
   input wire logic        CSR_DONE_O,
   input wire logic        DEBUG_MODE_O,
   input wire logic        EBREAK_TO_DEBUG_O,
   input wire logic        COUNT_STOP_O,
   input wire logic        MPRV_IGNORE_O
);
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   wire logic acc = CSR_VALID_I && CLK_EN_I;
   wire logic quiet = !(ENTER_TRIGGER_I || ENTER_RSTHALT_I || ENTER_HALTREQ_I
                        || INSN_RETIRE_I || INSN_EXCEPTION_I);
   a_compare_done: assert property (acc && CSR_ADDR_I == dhc_pkg::TCV_ADDR |=> CSR_DONE_O)
      else $error("compare value access not completed");
   a_idle_quiet: assert property (CLK_EN_I && !CSR_VALID_I |=> CSR_RDATA_O == 32'h0
      && !CSR_DONE_O && !CSR_ILLEGAL_O) else $error("bus outputs active without access");
   a_control_trap: assert property (acc && CSR_ADDR_I == dhc_pkg::DCS_ADDR && !DEBUG_MODE_O
      |=> CSR_ILLEGAL_O && !CSR_DONE_O) else $error("running control access not trapped");
   a_fixed_fields: assert property (CSR_DONE_O && $past(CSR_ADDR_I) == dhc_pkg::DCS_ADDR
      && !$past(CSR_WRITE_I) |-> CSR_RDATA_O[31:16] == 16'h4000 && CSR_RDATA_O[14:12] == 3'h0
      && !CSR_RDATA_O[9] && CSR_RDATA_O[5:4] == 2'h0) else $error("fixed control field wrong");
   a_mprv_mode: assert property (MPRV_IGNORE_O == DEBUG_MODE_O)
      else $error("privilege override ignore differs from halt");
   a_halt_entry: assert property (!DEBUG_MODE_O && CLK_EN_I && ENTER_HALTREQ_I |=> DEBUG_MODE_O)
      else $error("halt request did not halt");
   a_ebreak_gate: assert property (!DEBUG_MODE_O && CLK_EN_I && ENTER_EBREAK_I && quiet
      |=> DEBUG_MODE_O == $past(EBREAK_TO_DEBUG_O)) else $error("breakpoint gate wrong");
   a_count_stop: assert property (COUNT_STOP_O |-> DEBUG_MODE_O || $past(DEBUG_MODE_O)
      || $past(ENTER_EBREAK_I)) else $error("counters stopped while running");
   a_resume_run: assert property (DEBUG_MODE_O && CLK_EN_I && RESUME_I |=> !DEBUG_MODE_O)
      else $error("resume did not leave halt");
   a_halt_hold: assert property (DEBUG_MODE_O && !RESUME_I |=> DEBUG_MODE_O)
      else $error("halt dropped without resume");
endmodule : dhc_debug_csrs_chk
bind dhc_debug_csrs dhc_debug_csrs_chk dhc_debug_csrs_chk_i (.CORE_CLK_I, .SYS_RST_I,
   .CLK_EN_I, .CSR_VALID_I, .CSR_WRITE_I, .CSR_ADDR_I, .ENTER_TRIGGER_I, .ENTER_EBREAK_I,
   .ENTER_RSTHALT_I, .ENTER_HALTREQ_I, .RESUME_I, .INSN_RETIRE_I, .INSN_EXCEPTION_I,
   .CSR_RDATA_O, .CSR_ILLEGAL_O, .CSR_DONE_O, .DEBUG_MODE_O, .EBREAK_TO_DEBUG_O,
   .COUNT_STOP_O, .MPRV_IGNORE_O);
`default_nettype wire

// File: dv/dhc_dbg_model.sv
// Debugger model: register accesses, halt events and resume toward the hart
`timescale 1ns/1ps
`default_nettype none
module dhc_dbg_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic        done_i,
   input  wire logic        illegal_i,
   input  wire logic        halted_i,
   output logic             valid_o,
   output logic             write_o,
   output logic [11:0]      addr_o,
   output logic [31:0]      wdata_o,
   output logic [5:0]       ev_o,
   output logic             resume_o
);
   initial begin
      valid_o = 1'b0;
      write_o = 1'b0;
      addr_o = 12'h0;
      wdata_o = 32'h0;
      ev_o = 6'h0;
      resume_o = 1'b0;
   end
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] st);
      @(posedge clk_i);
      #1;
      valid_o = 1'b1;
      write_o = wr && (halted_i || a != dhc_pkg::DCS_ADDR);
      addr_o = a;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      valid_o = 1'b0;
      q = rdata_i;
      st = {illegal_i, done_i};
   endtask : acc
   task automatic fire(input logic [5:0] ev, input logic res);
      @(posedge clk_i);
      #1;
      ev_o = ev;
      // Resume is only meaningful from halt
      resume_o = res && halted_i;
      @(posedge clk_i);
      #1;
      ev_o = 6'h0;
      resume_o = 1'b0;
   endtask : fire
endmodule : dhc_dbg_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the debug halt control registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [23:0] PEV = {6'h01, 6'h03, 6'h07, 6'h0f};
   localparam logic [11:0] PCZ = {3'h3, 3'h5, 3'h1, 3'h2};
   localparam logic [11:0] TA = dhc_pkg::TCV_ADDR;
   localparam logic [11:0] DA = dhc_pkg::DCS_ADDR;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        nmi = 1'b0;
   logic        en = 1'b1;
   logic        sel = 1'b0;
   logic        msk = 1'b0;
   logic [1:0]  prv = 2'h3;
   logic [31:0] op = 32'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdata, wdata;
   logic [11:0] addr;
   logic [5:0]  ev;
   logic        valid, write, resume, done, ill, hit, halted, ebk, stie, cstop, mprv;
   int          fail_count = 0;
   int          compares = 0;
   always #2 clk = ~clk;
   dhc_debug_csrs dhc_debug_csrs_i (.CORE_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(en),
      .CSR_VALID_I(valid), .CSR_WRITE_I(write), .CSR_ADDR_I(addr), .CSR_WDATA_I(wdata),
      .TRIG_SELECT_I(sel), .TRIG_MASKED_I(msk), .TRIG_ADDRESS_I(op), .TRIG_DATA_I(dat),
      .ENTER_TRIGGER_I(ev[3]), .ENTER_EBREAK_I(ev[2]), .ENTER_RSTHALT_I(ev[1]),
      .ENTER_HALTREQ_I(ev[0]), .RESUME_I(resume), .INSN_RETIRE_I(ev[4]),
      .INSN_EXCEPTION_I(ev[5]), .CUR_PRIV_I(prv), .NMI_PENDING_I(nmi), .CSR_RDATA_O(rdata),
      .CSR_ILLEGAL_O(ill), .CSR_DONE_O(done), .TRIG_HIT_O(hit), .DEBUG_MODE_O(halted),
      .EBREAK_TO_DEBUG_O(ebk), .STEP_IRQ_EN_O(stie), .COUNT_STOP_O(cstop), .MPRV_IGNORE_O(mprv));
   dhc_dbg_model dhc_dbg_model_i (.clk_i(clk), .rdata_i(rdata), .done_i(done),
      .illegal_i(ill), .halted_i(halted), .valid_o(valid), .write_o(write), .addr_o(addr),
      .wdata_o(wdata), .ev_o(ev), .resume_o(resume));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [1:0] es);
      logic [31:0] q;
      logic [1:0]  st;
      dhc_dbg_model_i.acc(wr, a, d, q, st);
      chk({30'h0, st}, {30'h0, es});
      if (!wr) chk(q, e);
   endtask : xfer
   task automatic th(input logic [31:0] a, input logic [31:0] d, input logic s,
                     input logic m, input logic e);
      @(posedge clk);
      #1;
      {op, dat, sel, msk} = {a, d, s, m};
      @(posedge clk);
      #1;
      chk({31'h0, hit}, {31'h0, e});
   endtask : th
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic give_verdict();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #20000;
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      xfer(0, TA, 0, 32'h0, 2'b01);
      xfer(0, DA, 0, 32'h0, 2'b10);
      xfer(1, TA, 32'h1234_567f, 0, 2'b01);
      xfer(0, TA, 0, 32'h1234_567f, 2'b01);
      $display("test registers done");
      nmi = 1'b1;
      th(32'h1234_567f, 32'h0, 0, 0, 1);
      th(32'h0, 32'h1234_567f, 1, 0, 1);
      th(32'h1234_567f, 32'h0, 1, 0, 0);
      th(32'h1234_5600, 32'h0, 0, 1, 1);
      th(32'h1234_5700, 32'h0, 0, 1, 0);
      th(32'h1234_5600, 32'h0, 0, 0, 0);
      $display("test match done");
      dhc_dbg_model_i.fire(6'h01, 0);
      xfer(0, DA, 0, 32'h4000_00cb, 2'b01);
      dhc_dbg_model_i.fire(6'h08, 0);
      xfer(0, DA, 0, 32'h4000_00cb, 2'b01);
      xfer(1, DA, 32'hffff_ffff, 0, 2'b01);
      xfer(0, DA, 0, 32'h4000_8ccf, 2'b01);
      tick();
      chk({ebk, cstop}, 2'b11);
      chk({31'h0, mprv}, 32'h1);
      nmi = 1'b0;
      $display("test halt done");
      dhc_dbg_model_i.fire(6'h00, 1);
      tick();
      chk({halted, stie}, 2'b01);
      dhc_dbg_model_i.fire(6'h10, 0);
      xfer(0, DA, 0, 32'h4000_8d07, 2'b01);
      dhc_dbg_model_i.fire(6'h00, 1);
      dhc_dbg_model_i.fire(6'h20, 0);
      xfer(0, DA, 0, 32'h4000_8d07, 2'b01);
      xfer(1, DA, 32'h0000_8404, 0, 2'b01);
      dhc_dbg_model_i.fire(6'h00, 1);
      tick();
      chk({halted, stie, cstop}, 3'b000);
      dhc_dbg_model_i.fire(6'h10, 0);
      xfer(1, DA, 32'h0000_8400, 0, 2'b01);
      $display("test step done");
      for (int i = 0; i < 4; i++) begin
         dhc_dbg_model_i.fire(6'h00, 1);
         dhc_dbg_model_i.fire(PEV[i*6 +: 6], 0);
         xfer(0, DA, 0, 32'h4000_8403 | {23'h0, PCZ[i*3 +: 3], 6'h0}, 2'b01);
      end
      xfer(1, DA, 32'h0, 0, 2'b01);
      dhc_dbg_model_i.fire(6'h00, 1);
      dhc_dbg_model_i.fire(6'h04, 0);
      chk({31'h0, halted}, 32'h0);
      prv = 2'h1;
      dhc_dbg_model_i.fire(6'h01, 0);
      prv = 2'h3;
      xfer(0, DA, 0, 32'h4000_00c1, 2'b01);
      tick();
      en = 1'b0;
      dhc_dbg_model_i.fire(6'h00, 1);
      en = 1'b1;
      tick();
      chk({31'h0, halted}, 32'h1);
      $display("test cause done");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
